// file: core/bcd_counter_display_mux.v
/*
  Three-decade BCD event counter with hold latches and digit scanner.
  Assumes all inputs except reset_n_in are synchronous to core_clk_in; the count input and
  the external scan clock are sampled and edge-detected here.
*/
`timescale 1ns/10ps
`include "bcd_counter_defines.vh"

module bcd_counter_display_mux #(
  parameter SCAN_DIV = `SCAN_DIV_CYCLES
) (
  input  wire       core_clk_in,
  input  wire       reset_n_in,
  input  wire       count_in,
  input  wire       count_disable_in,
  input  wire       counter_clear_in,
  input  wire       hold_capture_in,
  input  wire       ext_scan_sel_in,
  input  wire       ext_scan_clk_in,
  output reg  [3:0] bcd_out,
  output reg  [2:0] digit_sel_n_out,
  output reg        overflow_out
);

  reg         rst_s1_q;
  reg         rst_n_q;
  reg         count_prev_q;
  reg         ext_prev_q;
  reg  [31:0] osc_cnt_q;
  reg         osc_tick_q;
  reg  [1:0]  scan_q;
  wire        count_fall;
  wire        advance;
  wire        scan_step;
  wire [2:0]  wrap;
  wire [11:0] counts;
  wire [11:0] latches;
  wire [3:0]  adv_chain;
  wire        ext_rise;
  wire [2:0]  sel_hit;
  wire        overflow_d;
  reg  [31:0] osc_cnt_d;
  reg         osc_tick_d;
  reg  [1:0]  scan_d;
  reg  [3:0]  bcd_d;
  reg  [2:0]  sel_n_d;

  // Release is synchronised so every flop reset by rst_n_q leaves reset on one edge

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Idle level of the count pin is low, so no false edge after reset
  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_prev_q <= 1'b0;
    end else begin
      count_prev_q <= count_in;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_scan_clk_in;
    end
  end

  assign count_fall = count_prev_q && !count_in;
  // Clear outranks counting; disable swallows the edge entirely
  assign advance = count_fall && !count_disable_in &&
                   !counter_clear_in;
  assign adv_chain[0] = advance;

  genvar g;
  // Each decade above the first steps only on the wrap of the one below
  generate
    for (g = 0; g < `DIGIT_COUNT; g = g + 1) begin : decade
      bcd_decade u_decade (
        .clk_in     (core_clk_in),
        .rst_n_in   (rst_n_q),
        .clear_in   (counter_clear_in),
        .advance_in (adv_chain[g]),
        .hold_in    (hold_capture_in),
        .count_q    (counts[4*g+3:4*g]),
        .latch_q    (latches[4*g+3:4*g]),
        .wrap_out   (wrap[g])
      );
      assign adv_chain[g+1] = wrap[g];
    end
  endgenerate

  // Internal scan oscillator, halted while clear is high
  always @* begin
    osc_cnt_d  = osc_cnt_q;
    osc_tick_d = 1'b0;
    if (counter_clear_in) begin
      osc_cnt_d = 32'h0;
    end else if (osc_cnt_q >= SCAN_DIV - 1) begin
      osc_cnt_d  = 32'h0;
      osc_tick_d = 1'b1;
    end else begin
      osc_cnt_d = osc_cnt_q + 32'h1;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_cnt_q  <= 32'h0;
      osc_tick_q <= 1'b0;
    end else begin
      osc_cnt_q  <= osc_cnt_d;
      osc_tick_q <= osc_tick_d;
    end
  end

  // External edges only matter while the override is selected
  assign ext_rise  = ext_scan_clk_in && !ext_prev_q;
  assign scan_step = ext_scan_sel_in ? ext_rise : osc_tick_q;

  always @* begin
    scan_d = scan_q;
    if (counter_clear_in) begin
      scan_d = `SCAN_FIRST;
    end else if (scan_step) begin
      if (scan_q == `SCAN_LAST) begin
        scan_d = `SCAN_FIRST;
      end else begin
        scan_d = scan_q + 2'h1;
      end
    end
  end

  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scan_q <= `SCAN_FIRST;
    end else begin
      scan_q <= scan_d;
    end
  end

  // One select decoder per digit position
  generate
    for (g = 0; g < `DIGIT_COUNT; g = g + 1) begin : sel_decode
      assign sel_hit[g] = (scan_q == g);
    end
  endgenerate

  // Shared digit bus follows the scanned latch
  always @* begin
    case (scan_q)
      2'h1:    bcd_d = latches[7:4];
      2'h2:    bcd_d = latches[11:8];
      default: bcd_d = latches[3:0];
    endcase
  end

  // Selects stay dark through clear to spare the display
  always @* begin
    if (counter_clear_in) begin
      sel_n_d = `SEL_IDLE;
    end else begin
      sel_n_d = ~sel_hit;
    end
  end

  assign overflow_d = wrap[2];

  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bcd_out <= 4'h0;
    end else begin
      bcd_out <= bcd_d;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      digit_sel_n_out <= `SEL_IDLE;
    end else begin
      digit_sel_n_out <= sel_n_d;
    end
  end

  // One clock wide, so a cascaded stage sees exactly one edge
  always @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      overflow_out <= 1'b0;
    end else begin
      overflow_out <= overflow_d;
    end
  end

endmodule

// file: core/bcd_counter_defines.vh
/*
  Shared constants for the three-decade counter and display scanner.
  Assumes inclusion by bare name from the core design files.
*/
`ifndef BCD_COUNTER_DEFINES_VH
`define BCD_COUNTER_DEFINES_VH

`define DECADE_MAX      4'h9
`define DECADE_ZERO     4'h0
`define DIGIT_COUNT     3
`define SEL_IDLE        3'h7
`define SCAN_FIRST      2'h0
`define SCAN_LAST       2'h2
`define CLK_PERIOD_NS   8
`define SCAN_PERIOD_NS  1000000
`define SCAN_DIV_CYCLES (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// file: core/bcd_decade.v
/*
  One BCD decade with its four-bit hold latch.
  Assumes the parent supplies a one-cycle advance strobe and a reset with synchronised release.
*/
`timescale 1ns/10ps
`include "bcd_counter_defines.vh"

module bcd_decade (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       clear_in,
  input  wire       advance_in,
  input  wire       hold_in,
  output reg  [3:0] count_q,
  output reg  [3:0] latch_q,
  output wire       wrap_out
);

  // Wrap only when this decade is really being stepped from nine
  assign wrap_out = advance_in && (count_q == `DECADE_MAX);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= `DECADE_ZERO;
    end else if (clear_in) begin
      count_q <= `DECADE_ZERO;
    end else if (advance_in) begin
      count_q <= wrap_out ? `DECADE_ZERO : count_q + 4'h1;
    end
  end

  // Transparent while hold is low, frozen while high
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= `DECADE_ZERO;
    end else if (!hold_in) begin
      latch_q <= clear_in ? `DECADE_ZERO : count_q;
    end
  end

endmodule

// file: bench/bcd_counter_display_mux_assertions.sv
/* Port checker for the counter and digit scanner.
   Assumes inputs synchronous to core_clk_in. */
`timescale 1ns/10ps
module bcd_counter_display_mux_checker (
  input wire       core_clk_in,
  input wire       reset_n_in,
  input wire       count_in,
  input wire       count_disable_in,
  input wire       counter_clear_in,
  input wire       hold_capture_in,
  input wire [3:0] bcd_out,
  input wire [2:0] digit_sel_n_out,
  input wire       overflow_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence frozen;
    (hold_capture_in && !counter_clear_in) [*6];
  endsequence
  sequence clr_end;
    counter_clear_in ##1 !counter_clear_in;
  endsequence
  chk_sel_code: assert property (
    digit_sel_n_out inside {3'h6, 3'h5, 3'h3, 3'h7}) else $error("bad sel");
  chk_scan_order: assert property (
    $changed(digit_sel_n_out) && digit_sel_n_out != 3'h7 &&
    $past(digit_sel_n_out) != 3'h7 |->
    {digit_sel_n_out[0], digit_sel_n_out[2:1]} == $past(digit_sel_n_out))
    else $error("scan order");
  chk_sel_clear: assert property (
    counter_clear_in [*3] |-> digit_sel_n_out == 3'h7) else $error("sel on");
  chk_first_digit: assert property (
    clr_end |-> ##[1:3] digit_sel_n_out == 3'h6) else $error("no restart");
  chk_sel_live: assert property (
    !counter_clear_in && !$past(counter_clear_in) &&
    $past(digit_sel_n_out) != 3'h7 |-> digit_sel_n_out != 3'h7)
    else $error("sel dropped");
  chk_ovf_pulse: assert property (
    overflow_out |=> !overflow_out) else $error("long overflow");
  chk_ovf_cause: assert property (
    overflow_out |-> !$past(count_in) && $past(count_in, 2) &&
    !$past(count_disable_in)) else $error("stray overflow");
  chk_hold_freeze: assert property (
    frozen |-> $stable(bcd_out) || $changed(digit_sel_n_out))
    else $error("latch moved");
endmodule
bind bcd_counter_display_mux bcd_counter_display_mux_checker chk (
  .core_clk_in, .reset_n_in, .count_in, .count_disable_in,
  .counter_clear_in, .hold_capture_in, .bcd_out, .digit_sel_n_out,
  .overflow_out);

// file: bench/scan_display.sv
/* Multiplexed display: keeps the digit of each active select.
   Assumes registered bcd and selects on clk_in. */
`timescale 1ns/10ps
module scan_display (
  input  wire        clk_in,
  input  wire [3:0]  bcd_in,
  input  wire [2:0]  sel_n_in,
  output logic [11:0] shown_out
);
  always @(posedge clk_in)
    for (int i = 0; i < 3; i++)
      if (!sel_n_in[i]) shown_out[4*i+:4] <= bcd_in;
endmodule

// file: bench/bcd_counter_display_mux_tb.sv
/* Bench for the counter with scanned display.
   Assumes SCAN_DIV of 4 and the display model. */
`timescale 1ns/10ps
module bcd_counter_display_mux_tb;
  logic core_clk_in = 0, reset_n_in = 0, count_in = 0, count_disable_in = 0;
  logic counter_clear_in = 0, hold_capture_in = 0;
  logic ext_scan_sel_in = 0, ext_scan_clk_in = 0, overflow_out;
  logic [3:0]  bcd_out;
  logic [2:0]  digit_sel_n_out;
  logic [11:0] shown;
  int          err_total = 0, checks = 0, ovf_n = 0;
  always #4 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) if (overflow_out === 1'b1) ovf_n++;
  bcd_counter_display_mux #(.SCAN_DIV(4)) uut (.core_clk_in, .reset_n_in,
    .count_in, .count_disable_in, .counter_clear_in, .hold_capture_in,
    .ext_scan_sel_in, .ext_scan_clk_in, .bcd_out, .digit_sel_n_out,
    .overflow_out);
  scan_display disp (.clk_in(core_clk_in), .bcd_in(bcd_out),
    .sel_n_in(digit_sel_n_out), .shown_out(shown));
  task cmp(input logic [11:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task pulse(input int n);
    repeat (n) begin
      @(posedge core_clk_in) count_in <= 1;
      @(posedge core_clk_in) count_in <= 0;
    end
    cyc(4);
  endtask
  task view(input logic [11:0] exp);
    cyc(24);
    @(negedge core_clk_in);
    cmp(shown, exp);
    @(posedge core_clk_in);
  endtask
  task t_disable;
    count_disable_in <= 1;
    pulse(5);
    count_disable_in <= 0;
    view(12'h123);
  endtask
  task t_hold;
    hold_capture_in <= 1;
    pulse(4);
    view(12'h123);
    counter_clear_in <= 1;
    cyc(4);
    @(negedge core_clk_in);
    cmp({9'h0, digit_sel_n_out}, 12'h007);
    @(posedge core_clk_in);
    counter_clear_in <= 0;
    pulse(4);
    view(12'h123);
    hold_capture_in <= 0;
    view(12'h004);
  endtask
  task t_ovf;
    pulse(995);
    view(12'h999);
    pulse(1);
    view(12'h000);
    cmp(12'(ovf_n), 12'h001);
  endtask
  task t_ext;
    logic [2:0] s;
    ext_scan_sel_in <= 1;
    cyc(8);
    @(negedge core_clk_in);
    s = digit_sel_n_out;
    cyc(20);
    @(negedge core_clk_in);
    cmp({9'h0, digit_sel_n_out}, {9'h0, s});
    @(posedge core_clk_in);
    ext_scan_clk_in <= 1;
    cyc(4);
    ext_scan_clk_in <= 0;
    cyc(4);
    @(negedge core_clk_in);
    cmp({9'h0, digit_sel_n_out}, {9'h0, s[1:0], s[2]});
    @(posedge core_clk_in);
  endtask
  task final_report;
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    reset_n_in <= 1;
    cyc(4);
    pulse(123);
    view(12'h123);
    t_disable;
    t_hold;
    t_ovf;
    t_ext;
    final_report;
  end
  initial begin
    #60000;
    err_total++;
    final_report;
  end
endmodule
